// ### src/tmr8_pkg.sv
// Package for the 8-bit timer with two compare channels: offsets, fields, modes
package tmr8_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] ADDR_COUNT    = 8'h08;
  localparam logic [7:0] ADDR_CMP_A    = 8'h0c;
  localparam logic [7:0] ADDR_CMP_B    = 8'h10;
  localparam logic [7:0] ADDR_FLAG     = 8'h14;
  localparam logic [7:0] ADDR_MASK     = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ACK  = 8'h1c;
  // Control A fields
  localparam int CA_COM_A_LSB = 6;
  localparam int CA_COM_B_LSB = 4;
  localparam int CA_WGM_LSB   = 0;
  // Control B fields
  localparam int CB_FOC_A     = 7;
  localparam int CB_FOC_B     = 6;
  localparam int CB_WGM2      = 3;
  localparam int CB_CS_LSB    = 0;
  // Flag and mask bit positions
  localparam int FL_OVF   = 0;
  localparam int FL_CMP_A = 1;
  localparam int FL_CMP_B = 2;
  // Counter extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  // Waveform modes
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_PC_MAX   = 3'h1;
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_OCRA  = 3'h5;
  localparam logic [2:0] WGM_FAST_OCRA = 3'h7;
  // Tick source selections
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Compare output mode codes
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;
  // AHB transfer codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  // Per-channel output compare state
  typedef struct packed {
    logic [7:0] buf_val;
    logic [7:0] act_val;
    logic       wave;
    logic       match_d1;
  } tmr8_chan_s;

  // Whole state of the timer
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] wgm;
    logic [2:0] cs;
    logic [7:0] count;
    logic       down;
    logic       block;
    logic [2:0] flags;
    logic [2:0] mask;
    logic [9:0] presc;
    logic       ext_q;
    tmr8_chan_s ch_a;
    tmr8_chan_s ch_b;
    logic       ap_valid;
    logic       ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } tmr8_state_s;

  // Modes 1,3,5,7 are PWM
  function automatic logic tmr8_is_pwm(input logic [2:0] wgm);
    return wgm[0];
  endfunction : tmr8_is_pwm
endpackage : tmr8_pkg

// ### src/tmr8_timer.sv
// Eight-bit timer with two compare channels and an AHB-Lite register slave
// Behaviour
// - Count and two compare values are 8-bit
// - Bottom is 0x00, maximum is 0xFF
// - Top is 0xFF or compare A by mode
// - Tick from prescaler or external input; 0 stops
// - Counter readable and writable at any time
// - CPU counter write beats count or clear
// - Each tick clears, increments or decrements counter
// - Overflow flag set per mode, can interrupt
// - Counter compared to both values continuously
// - Compare flag set one tick after match
// - Flag cleared by service or writing one
// - Three flags shown, each gated by mask
// - Compare buffered only in PWM modes
// - Buffer copied to active at top
// - CPU reaches buffer or active register
// - Force strobe updates output in non-PWM modes, not flag, counter
// - Counter write blocks next tick's matches
// - Output mode bits act immediately
// - Output state kept across mode switches
// - Waveform uses match, mode, max and bottom
// - Mode 0 counts up, overflow at wrap
// - Mode 2 clears on compare A match
// - Modes 3,7 single slope, top 0xFF or A
// - Output mode 0 leaves output unchanged
`timescale 1ns/1ns
module tmr8_timer
  import tmr8_pkg::*;
#(
  parameter int PRESC_WIDTH = 10
) (
  input  wire logic        hclk,          // System clock, 20 MHz
  input  wire logic        hresetn,       // Asynchronous reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [7:0]  haddr,         // Byte address, low bits
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready in
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Always OKAY
  input  wire logic        external_count_input, // External tick pin
  input  wire logic [2:0]  irq_serviced,  // Pulse per flag when its vector runs
  output logic      [2:0]  irq_req,       // Masked requests: ovf, cmp a, cmp b
  output logic             wave_out_a,    // Output compare state a
  output logic             wave_out_b,    // Output compare state b
  output logic             wave_en_a,     // Pin override active a
  output logic             wave_en_b      // Pin override active b
);

  initial begin
    if (PRESC_WIDTH != 10) $error("PRESC_WIDTH must be 10 for the divide by 1024 tap");
  end

  tmr8_state_s s_q;
  tmr8_state_s s_d;

  logic [2:0]  wgm;
  logic        pwm;
  logic [7:0]  top;
  logic        tick;
  logic        at_top;
  logic        at_bottom;
  logic        match_a;
  logic        match_b;
  logic        wr_en;
  logic        wr_count;
  logic [7:0]  wd;
  logic        ext_rise;
  logic        ext_fall;

  assign wgm = s_q.wgm;
  assign pwm = tmr8_is_pwm(wgm);
  // Top is max or compare A by mode
  assign top = (wgm == WGM_CTC || wgm == WGM_FAST_OCRA || wgm == WGM_PC_OCRA)
               ? s_q.ch_a.act_val : CNT_MAX;
  assign at_top    = (s_q.count == top);
  assign at_bottom = (s_q.count == CNT_BOTTOM);
  // Continuous compare, blocked the tick after a counter write
  assign match_a = (s_q.count == s_q.ch_a.act_val) && !s_q.block;
  assign match_b = (s_q.count == s_q.ch_b.act_val) && !s_q.block;

  // Tick source select; prescaler taps come from a free running count
  assign ext_rise = external_count_input && !s_q.ext_q;
  assign ext_fall = !external_count_input && s_q.ext_q;
  always_comb begin
    case (s_q.cs)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (s_q.presc[2:0] == 3'h7);
      CS_DIV64:    tick = (s_q.presc[5:0] == 6'h3f);
      CS_DIV256:   tick = (s_q.presc[7:0] == 8'hff);
      CS_DIV1024:  tick = (s_q.presc == 10'h3ff);
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  // Bus write is performed in the data phase; no wait states
  assign wr_en    = s_q.ap_valid && s_q.ap_write;
  assign wd       = hwdata[7:0];                  // no register is wider than 8 bits
  assign wr_count = wr_en && (s_q.ap_addr == ADDR_COUNT);

  // Next-state logic for the whole block
  always_comb begin
    logic [7:0] cnt_n;
    logic [1:0] com;
    logic       ovf_set;
    cnt_n = s_q.count;
    com   = COM_NONE;
    // Overflow is applied after the clears so that the hardware set wins
    ovf_set = 1'b0;
    s_d = s_q;
    s_d.ext_q = external_count_input;
    s_d.presc = s_q.presc + 10'h001;

    // Address phase capture
    if (hready) begin
      s_d.ap_valid = hsel && (htrans == HTRANS_NONSEQ);
      s_d.ap_write = hwrite;
      s_d.ap_addr  = haddr;
    end

    // Counter sequencing
    if (tick) begin
      s_d.block = 1'b0;
      if (wgm == WGM_PC_MAX || wgm == WGM_PC_OCRA) begin
        // Dual slope: turn at top and bottom
        if (!s_q.down && at_top) begin
          s_d.down = 1'b1;
          cnt_n = s_q.count - 8'h01;
        end else if (s_q.down && at_bottom) begin
          s_d.down = 1'b0;
          cnt_n = s_q.count + 8'h01;
          ovf_set = 1'b1;
        end else begin
          cnt_n = s_q.down ? s_q.count - 8'h01 : s_q.count + 8'h01;
        end
      end else if (wgm == WGM_CTC && at_top) begin
        cnt_n = CNT_BOTTOM;
        if (s_q.count == CNT_MAX) ovf_set = 1'b1;
      end else if ((wgm == WGM_FAST_MAX || wgm == WGM_FAST_OCRA) && at_top) begin
        cnt_n = CNT_BOTTOM;
        ovf_set = 1'b1;
      end else begin
        s_d.down = 1'b0;
        cnt_n = s_q.count + 8'h01;
        if (s_q.count == CNT_MAX) ovf_set = 1'b1;       // wrap to zero
      end
      // Match latched this tick raises flag next tick
      if (s_q.ch_a.match_d1) s_d.flags[FL_CMP_A] = 1'b1;
      if (s_q.ch_b.match_d1) s_d.flags[FL_CMP_B] = 1'b1;
      s_d.ch_a.match_d1 = match_a;
      s_d.ch_b.match_d1 = match_b;
      // Buffer update at top, in both fast and phase correct modes
      if (pwm && at_top) begin
        s_d.ch_a.act_val = s_q.ch_a.buf_val;
        s_d.ch_b.act_val = s_q.ch_b.buf_val;
      end
    end
    s_d.count = cnt_n;

    // Waveform generator; mode bits used live, not buffered
    for (int ch = 0; ch < 2; ch++) begin
      logic m;
      logic w;
      logic force_s;
      m       = (ch == 0) ? match_a : match_b;
      w       = (ch == 0) ? s_q.ch_a.wave : s_q.ch_b.wave;
      com     = (ch == 0) ? s_q.com_a : s_q.com_b;
      force_s = wr_en && (s_q.ap_addr == ADDR_CTRL_B) && !pwm
                && wd[(ch == 0) ? CB_FOC_A : CB_FOC_B];
      if ((tick && m) || force_s) begin
        if (!pwm) begin
          case (com)
            COM_TOGGLE: w = !w;
            COM_CLEAR:  w = 1'b0;
            COM_SET:    w = 1'b1;
            default:    w = w;
          endcase
        end else if (com == COM_CLEAR || com == COM_SET) begin
          w = (com == COM_SET);
        end
      end else if (tick && pwm && at_top && !(wgm == WGM_PC_MAX || wgm == WGM_PC_OCRA)
                   && (com == COM_CLEAR || com == COM_SET)) begin
        w = (com == COM_CLEAR);                               // Set at bottom, non-inverting
      end
      if (ch == 0) s_d.ch_a.wave = w;
      else         s_d.ch_b.wave = w;
    end

    // Interrupt service clears flags
    s_d.flags = s_d.flags & ~irq_serviced;

    // Register writes; the counter write overrides the sequencer
    if (wr_en) begin
      case (s_q.ap_addr)
        ADDR_CTRL_A: begin
          s_d.com_a   = wd[CA_COM_A_LSB +: 2];
          s_d.com_b   = wd[CA_COM_B_LSB +: 2];
          s_d.wgm[1:0] = wd[CA_WGM_LSB +: 2];   // wave state untouched
        end
        ADDR_CTRL_B: begin
          s_d.wgm[2] = wd[CB_WGM2];
          s_d.cs     = wd[CB_CS_LSB +: 3];
        end
        ADDR_COUNT: begin
          s_d.count = wd;
          s_d.block = 1'b1;
        end
        ADDR_CMP_A: begin
          if (pwm) s_d.ch_a.buf_val = wd;
          else begin
            s_d.ch_a.buf_val = wd;
            s_d.ch_a.act_val = wd;
          end
        end
        ADDR_CMP_B: begin
          if (pwm) s_d.ch_b.buf_val = wd;
          else begin
            s_d.ch_b.buf_val = wd;
            s_d.ch_b.act_val = wd;
          end
        end
        ADDR_FLAG: s_d.flags = s_d.flags & ~wd[2:0];
        ADDR_MASK: s_d.mask  = wd[2:0];
        default: ;
      endcase
    end
    // A hardware set in this cycle wins over a software clear
    if (tick && s_q.ch_a.match_d1) s_d.flags[FL_CMP_A] = 1'b1;
    if (tick && s_q.ch_b.match_d1) s_d.flags[FL_CMP_B] = 1'b1;
    if (ovf_set) s_d.flags[FL_OVF] = 1'b1;

    // Read data for the next data phase
    s_d.rdata = 32'h0000_0000;
    if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
      case (haddr)
        ADDR_CTRL_A: s_d.rdata[7:0] = {s_q.com_a, s_q.com_b, 2'h0, s_q.wgm[1:0]};
        ADDR_CTRL_B: s_d.rdata[7:0] = {4'h0, s_q.wgm[2], s_q.cs};
        ADDR_COUNT:  s_d.rdata[7:0] = s_d.count;
        ADDR_CMP_A:  s_d.rdata[7:0] = pwm ? s_q.ch_a.buf_val : s_q.ch_a.act_val;
        ADDR_CMP_B:  s_d.rdata[7:0] = pwm ? s_q.ch_b.buf_val : s_q.ch_b.act_val;
        ADDR_FLAG:   s_d.rdata[7:0] = {5'h00, s_d.flags};
        ADDR_MASK:   s_d.rdata[7:0] = {5'h00, s_q.mask};
        default:     s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; everything resets to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY[0];
  assign irq_req   = s_q.flags & s_q.mask;
  assign wave_out_a = s_q.ch_a.wave;
  assign wave_out_b = s_q.ch_b.wave;
  assign wave_en_a  = (s_q.com_a != COM_NONE);
  assign wave_en_b  = (s_q.com_b != COM_NONE);

  // Match on a tick raises the flag at the following tick
  property p_flag_after_match;
    @(posedge hclk) disable iff (!hresetn)
      (tick && match_a) ##1 tick |=> s_q.flags[FL_CMP_A];
  endproperty
  a_flag_after_match: assert property (p_flag_after_match) else $error("cmp a flag late");

  property p_write_blocks;
    @(posedge hclk) disable iff (!hresetn)
      wr_count |=> !match_a && !match_b;
  endproperty
  a_write_blocks: assert property (p_write_blocks) else $error("match not blocked");

  property p_write_wins;
    @(posedge hclk) disable iff (!hresetn)
      wr_count |=> s_q.count == $past(hwdata[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost");

  property p_stopped;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.cs == CS_STOP && !wr_en) |=> s_q.count == $past(s_q.count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_ctc_clear;
    @(posedge hclk) disable iff (!hresetn)
      (tick && wgm == WGM_CTC && at_top && !wr_en) |=> s_q.count == CNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on match");

  property p_normal_ovf;
    @(posedge hclk) disable iff (!hresetn)
      (tick && wgm == WGM_NORMAL && s_q.count == CNT_MAX && !wr_en)
        |=> s_q.count == CNT_BOTTOM && s_q.flags[FL_OVF];
  endproperty
  a_normal_ovf: assert property (p_normal_ovf) else $error("no overflow at wrap");

  property p_irq_mask;
    @(posedge hclk) disable iff (!hresetn)
      irq_req[FL_CMP_B] |-> s_q.mask[FL_CMP_B] && s_q.flags[FL_CMP_B];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("unmasked request");

  property p_com_none;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.com_a == COM_NONE && !(wr_en && s_q.ap_addr == ADDR_CTRL_A))
        |=> wave_out_a == $past(wave_out_a);
  endproperty
  a_com_none: assert property (p_com_none) else $error("output moved with mode 0");

  property p_nobuf;
    @(posedge hclk) disable iff (!hresetn)
      (wr_en && s_q.ap_addr == ADDR_CMP_B && !pwm) |=> s_q.ch_b.act_val == $past(hwdata[7:0]);
  endproperty
  a_nobuf: assert property (p_nobuf) else $error("unbuffered write missed");

  // In PWM modes the active value only moves at the turning point
  property p_buf_load;
    @(posedge hclk) disable iff (!hresetn)
      (tick && pwm && at_top) |=> s_q.ch_a.act_val == $past(s_q.ch_a.buf_val);
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("buffer not loaded at top");

  // A buffered write must not disturb the compare in use, avoiding odd pulses
  property p_buf_hold;
    @(posedge hclk) disable iff (!hresetn)
      (pwm && !(tick && at_top)) |=> $stable(s_q.ch_b.act_val);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("active compare moved early");

  // Single slope restarts from bottom and flags overflow at top
  property p_fast_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (tick && (wgm == WGM_FAST_MAX || wgm == WGM_FAST_OCRA) && at_top && !wr_count)
        |=> s_q.count == CNT_BOTTOM && s_q.flags[FL_OVF];
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast mode did not restart");

  // A force strobe alone never touches the flags
  property p_force_no_flag;
    @(posedge hclk) disable iff (!hresetn)
      (wr_en && s_q.ap_addr == ADDR_CTRL_B && !tick && irq_serviced == 3'h0)
        |=> s_q.flags == $past(s_q.flags);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set a flag");

endmodule : tmr8_timer

// ### test/tmr8_timer_tb_top.sv
// Self-checking testbench for the eight-bit timer, driven over AHB-Lite
`timescale 1ns/1ns
module tmr8_timer_tb_top
  import tmr8_pkg::*;
;
  logic        hclk;                  // Bench clock
  logic        hresetn;               // Bench reset
  logic        hsel;                  // Select
  logic [7:0]  haddr;                 // Address
  logic [1:0]  htrans;                // Transfer type
  logic        hwrite;                // Write strobe
  logic [2:0]  hsize;                 // Size
  logic [31:0] hwdata;                // Write data
  logic [31:0] hrdata;                // Read data
  logic        hreadyout;             // Slave ready, also bus ready
  logic        hresp;                 // Response
  logic        ext_in;                // External tick pin
  logic [2:0]  irq_serviced;          // Service pulses
  logic [2:0]  irq_req;               // Masked requests
  logic        wave_out_a;            // Output state a
  logic        wave_out_b;            // Output state b
  logic        wave_en_a;             // Override a
  logic        wave_en_b;             // Override b
  int          error_cnt;             // Mismatches
  int          checked;               // Comparisons
  logic [31:0] rd;                    // Last read value

  tmr8_timer u_tmr8_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_count_input(ext_in),
    .irq_serviced(irq_serviced), .irq_req(irq_req), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .wave_en_a(wave_en_a), .wave_en_b(wave_en_b));

  // 50 ns clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // One AHB transfer; read data is taken at the ready edge that ends the data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(negedge hclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    xfer(1'b0, a, 32'h0);
    check(rd, exp, msg);
  endtask : rd_chk

  // Run the prescaler at full rate for n clocks, then stop it
  task automatic run(input int n);
    wr(ADDR_CTRL_B, 32'h1);
    repeat (n) @(posedge hclk);
    wr(ADDR_CTRL_B, 32'h0);
  endtask : run

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge hclk) ext_in <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_in <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask : pulses

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the several hundred clocks the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; ext_in = 1'b0; irq_serviced = 3'h0;
    error_cnt = 0; checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Every register and an unmapped place read zero after reset
    for (int a = 0; a <= 8'h20; a += 4) rd_chk(a[7:0], 32'h0, "reset value");
    check(32'({irq_req, wave_out_a, wave_out_b}), 32'h0, "outputs after reset");
    check(32'(hresp), 32'h0, "okay response");
    $display("Test reset done");
    // Stopped counter stays readable and writable
    wr(ADDR_COUNT, 32'ha5);
    repeat (10) @(posedge hclk);
    rd_chk(ADDR_COUNT, 32'ha5, "count held while stopped");
    wr(ADDR_CMP_A, 32'h5a);
    rd_chk(ADDR_CMP_A, 32'h5a, "compare a direct");
    $display("Test access done");
    // Counter write equal to compare b blocks that match; a later match on a still flags
    wr(ADDR_CMP_B, 32'h20);
    wr(ADDR_CMP_A, 32'h22);
    wr(ADDR_COUNT, 32'h20);
    run(6);
    rd_chk(ADDR_FLAG, 32'h2, "only compare a flagged");
    wr(ADDR_FLAG, 32'h2);
    rd_chk(ADDR_FLAG, 32'h0, "write one clears");
    $display("Test blocking done");
    // Normal mode wraps past the maximum and flags overflow
    wr(ADDR_COUNT, 32'hfc);
    run(8);
    rd_chk(ADDR_FLAG, 32'h1, "overflow flag");
    xfer(1'b0, ADDR_COUNT, 32'h0);
    check(32'(rd < 32'h10), 32'h1, "count wrapped to bottom");
    check(32'(irq_req), 32'h0, "masked request");
    wr(ADDR_MASK, 32'h1);
    check(32'(irq_req), 32'h1, "unmasked request");
    @(posedge hclk) irq_serviced <= 3'h1;
    @(posedge hclk) irq_serviced <= 3'h0;
    @(negedge hclk);
    check(32'(irq_req), 32'h0, "service clears request");
    rd_chk(ADDR_FLAG, 32'h0, "service clears flag");
    $display("Test overflow done");
    // Clear-on-match mode keeps the count at or below compare a
    wr(ADDR_CMP_A, 32'h3);
    wr(ADDR_CTRL_A, 32'h2);
    wr(ADDR_COUNT, 32'h0); // differs from both compare values
    run(30);
    xfer(1'b0, ADDR_COUNT, 32'h0);
    check(32'(rd <= 32'h3), 32'h1, "count bounded by compare a");
    rd_chk(ADDR_FLAG, 32'h2, "match flag, no overflow");
    wr(ADDR_FLAG, 32'h7);
    $display("Test clear on match done");
    // Force strobes act at once, set no flag; mode 0 of output does nothing
    wr(ADDR_CTRL_A, 32'h40);
    check(32'(wave_en_a), 32'h1, "override follows output mode");
    wr(ADDR_CTRL_B, 32'h80);
    check(32'(wave_out_a), 32'h1, "force toggles a");
    rd_chk(ADDR_FLAG, 32'h0, "force sets no flag");
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, 32'h80);
    check(32'({wave_out_a, wave_en_a}), 32'h2, "output mode 0 leaves state");
    wr(ADDR_CTRL_A, 32'h30);
    wr(ADDR_CTRL_B, 32'h40);
    check(32'(wave_out_b), 32'h1, "force sets b");
    check(32'(wave_en_b), 32'h1, "override b follows output mode");
    // Switching to a PWM mode keeps both states; force is ignored there
    wr(ADDR_CTRL_A, 32'h43);
    wr(ADDR_CTRL_B, 32'h80);
    check(32'({wave_out_a, wave_out_b}), 32'h3, "states kept, force ignored");
    wr(ADDR_CMP_B, 32'h77);
    rd_chk(ADDR_CMP_B, 32'h77, "buffer read back");
    // Run past the top so the buffer lands, then read the active value in normal mode
    run(260);
    wr(ADDR_CTRL_A, 32'h0);
    rd_chk(ADDR_CMP_B, 32'h77, "buffer loaded at top");
    $display("Test force done");
    // External pin ticks on the selected edge; selection 0 stops counting
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL_B, 32'h7);
    pulses(3);
    rd_chk(ADDR_COUNT, 32'h3, "rising edges counted");
    wr(ADDR_CTRL_B, 32'h6);
    pulses(2);
    rd_chk(ADDR_COUNT, 32'h5, "falling edges counted");
    wr(ADDR_CTRL_B, 32'h0);
    pulses(2);
    rd_chk(ADDR_COUNT, 32'h5, "stopped ignores pin");
    $display("Test external tick done");
    print_verdict();
  end
endmodule : tmr8_timer_tb_top
